// ---- src/tpw_pkg.sv ----
package tpw_pkg;
    // byte register offsets
    localparam logic [3:0] OFF_CTRL_TWO = 4'h0;
    localparam logic [3:0] OFF_CTRL_ONE = 4'h1;
    localparam logic [3:0] OFF_STATUS = 4'h2;
    localparam logic [3:0] OFF_CAP1_HI = 4'h3;
    localparam logic [3:0] OFF_CAP1_LO = 4'h4;
    localparam logic [3:0] OFF_CMP1_HI = 4'h5;
    localparam logic [3:0] OFF_CMP1_LO = 4'h6;
    localparam logic [3:0] OFF_CNT_HI = 4'h7;
    localparam logic [3:0] OFF_CNT_LO = 4'h8;
    localparam logic [3:0] OFF_ACNT_HI = 4'h9;
    localparam logic [3:0] OFF_ACNT_LO = 4'ha;
    localparam logic [3:0] OFF_CAP2_HI = 4'hb;
    localparam logic [3:0] OFF_CAP2_LO = 4'hc;
    localparam logic [3:0] OFF_CMP2_HI = 4'hd;
    localparam logic [3:0] OFF_CMP2_LO = 4'he;

    // reset values and counter top
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_CMP = 16'h8000;
    localparam logic [15:0] RST_CNT = 16'hfffc;
    localparam logic [15:0] CNT_TOP = 16'hffff;

    // tick source selection
    localparam logic [1:0] SEL_DIV4 = 2'b00;
    localparam logic [1:0] SEL_DIV2 = 2'b01;
    localparam logic [1:0] SEL_DIV8 = 2'b10;
    localparam logic [1:0] SEL_EXT = 2'b11;

    // control one field layout, bit 7 first
    typedef struct packed {
        logic captureInterruptEnable;
        logic compareInterruptEnable;
        logic overflowInterruptEnable;
        logic forceLevelTwo;
        logic forceLevelOne;
        logic levelAfterCompareTwo;
        logic captureEdgeOne;
        logic levelAfterCompareOne;
    } tpw_ctrl_one_t;

    // control two field layout, bit 7 first
    typedef struct packed {
        logic compareOnePinEnable;
        logic compareTwoPinEnable;
        logic singlePulseSelect;
        logic pwmEnable;
        logic [1:0] timerClockSelect;
        logic captureEdgeTwo;
        logic extClockEdge;
    } tpw_ctrl_two_t;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wrData;
        logic wrStb;
        logic rdStb;
    } tpw_bus_t;
endpackage

// ---- src/tpw_timer.sv ----
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - pwm owns compare one and compare two
// - pwm matches drive output one levels
// - high pulse spans compare two minus one
// - equal levels give a constant output
// - pwm compare two match reloads counter fffc
// - compare value is ticks minus five
// - high byte write inhibits until low
// - no compare flags while pwm runs
// - pwm compare two match sets capture flag one
// - capture one off, capture two works
// - pwm wins over single pulse select
// - wait unaffected, wake; never from halt
// - halt freezes counter and prescaler
// - halt capture edge arms, flags at exit
// - one shared gated interrupt request
// - capture enable gates both capture flags
// - compare enable gates both compare flags
// - overflow enable gates overflow flag
// - force two copies level two to pin
// - clock select picks tick source
// - flag clears after status then low access
// - pwm gives a repeating waveform
module tpw_timer (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    // register port
    input wire tpw_pkg::tpw_bus_t bus,
    output logic [7:0] rdData,
    // pins
    input wire logic captureInputOne,
    input wire logic captureInputTwo,
    input wire logic extClockIn,
    output logic compareOutputOne,
    output logic compareOutputTwo,
    // core side
    input wire logic globalInterruptMask,
    input wire logic waitMode,
    input wire logic haltMode,
    output logic timerIrq,
    output logic waitWake
);
    import tpw_pkg::*;

    localparam int W_MIN = 1;
    localparam int W_MAX = 1;

    function automatic logic hit(input tpw_bus_t b, input logic [3:0] off);
        hit = (b.wrStb | b.rdStb) && (b.addr == off);
    endfunction

    function automatic logic edgeOk(input logic prv, input logic now,
                                    input logic rising);
        edgeOk = rising ? (!prv && now) : (prv && !now);
    endfunction

    ////////////////////////////////////////////////////////////////////
    tpw_ctrl_one_t ctrlOne_ff;
    tpw_ctrl_two_t ctrlTwo_ff;
    logic [15:0] cmpOne_ff, cmpTwo_ff, cnt_ff, capOne_ff, capTwo_ff;
    logic inhOne_ff, inhTwo_ff;
    logic capture_flag_one_ff, compare_flag_one_ff, tof_ff, capture_flag_two_ff, compare_flag_two_ff;
    logic [4:0] armClr_ff;
    logic [2:0] pre_ff;
    logic [2:0] syncA_ff, syncB_ff, prev_ff;
    logic [1:0] haltArm_ff;
    logic haltPrev_ff;
    logic [7:0] rdData_ff;
    logic outOne_ff, outTwo_ff, irq_ff, wake_ff;

    logic run, tick, pwmOn, opmOn, matchOne, matchTwo, haltExit;
    logic edgeOne, edgeTwo, wrLowOne, wrLowTwo;
    logic setIcf1, setOcf1, setTof, setIcf2, setOcf2;
    logic [4:0] lowAcc;
    logic [7:0] statusByte;

    // timer stops in halt, bus keeps clkEn only
    assign run = clkEn && !haltMode;
    assign pwmOn = ctrlTwo_ff.pwmEnable;
    assign opmOn = ctrlTwo_ff.singlePulseSelect && !pwmOn;
    assign haltExit = haltPrev_ff && !haltMode;
    assign statusByte = {capture_flag_one_ff, compare_flag_one_ff, tof_ff, capture_flag_two_ff, compare_flag_two_ff,
                         3'h0};

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage a feeds only stage b
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    syncA_ff[gi] <= 1'b0;
                    syncB_ff[gi] <= 1'b0;
                    prev_ff[gi] <= 1'b0;
                end else if (clkEn) begin
                    syncA_ff[gi] <= (gi == 0) ? captureInputOne :
                                    (gi == 1) ? captureInputTwo :
                                    extClockIn;
                    syncB_ff[gi] <= syncA_ff[gi];
                    prev_ff[gi] <= syncB_ff[gi];
                end
            end
        end
    endgenerate

    assign edgeOne = edgeOk(prev_ff[0], syncB_ff[0],
                            ctrlOne_ff.captureEdgeOne) && !pwmOn;
    assign edgeTwo = edgeOk(prev_ff[1], syncB_ff[1],
                            ctrlTwo_ff.captureEdgeTwo);

    ////////////////////////////////////////////////////////////////////
    // prescaler free runs; divide ratios share one counter
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_ff <= 3'h0;
        end else if (run) begin
            pre_ff <= pre_ff + 3'h1;
        end
    end

    always_comb begin
        case (ctrlTwo_ff.timerClockSelect)
            SEL_DIV4: tick = (pre_ff[1:0] == 2'h3);
            SEL_DIV2: tick = pre_ff[0];
            SEL_DIV8: tick = (pre_ff == 3'h7);
            SEL_EXT: tick = edgeOk(prev_ff[2], syncB_ff[2],
                                   ctrlTwo_ff.extClockEdge);
            default: tick = 1'b0;
        endcase
    end

    // matches blocked while a high byte waits for its low byte
    assign matchOne = tick && (cnt_ff == cmpOne_ff) && !inhOne_ff;
    assign matchTwo = tick && (cnt_ff == cmpTwo_ff) && !inhTwo_ff;

    ////////////////////////////////////////////////////////////////////
    // free running counter; frozen in halt
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= RST_CNT;
        end else if (clkEn && bus.wrStb && bus.addr == OFF_CNT_LO) begin
            cnt_ff <= RST_CNT;
        end else if (run && tick) begin
            if (pwmOn && matchTwo) begin
                cnt_ff <= RST_CNT;
            end else begin
                cnt_ff <= cnt_ff + 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrlOne_ff <= tpw_ctrl_one_t'(RST_CTRL);
            ctrlTwo_ff <= tpw_ctrl_two_t'(RST_CTRL);
        end else if (clkEn && bus.wrStb) begin
            if (bus.addr == OFF_CTRL_ONE) begin
                ctrlOne_ff <= tpw_ctrl_one_t'(bus.wrData);
            end
            if (bus.addr == OFF_CTRL_TWO) begin
                ctrlTwo_ff <= tpw_ctrl_two_t'(bus.wrData);
            end
        end
    end

    // software writes ticks minus five; taken as stored
    assign wrLowOne = bus.wrStb && bus.addr == OFF_CMP1_LO;
    assign wrLowTwo = bus.wrStb && bus.addr == OFF_CMP2_LO;

    // compare registers with high-byte inhibit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmpOne_ff <= RST_CMP;
            cmpTwo_ff <= RST_CMP;
            inhOne_ff <= 1'b0;
            inhTwo_ff <= 1'b0;
        end else if (clkEn && bus.wrStb) begin
            // inhibit set by high, freed by low
            if (bus.addr == OFF_CMP1_HI) begin
                cmpOne_ff[15:8] <= bus.wrData;
                inhOne_ff <= 1'b1;
            end
            if (wrLowOne) begin
                cmpOne_ff[7:0] <= bus.wrData;
                inhOne_ff <= 1'b0;
            end
            if (bus.addr == OFF_CMP2_HI) begin
                cmpTwo_ff[15:8] <= bus.wrData;
                inhTwo_ff <= 1'b1;
            end
            if (wrLowTwo) begin
                cmpTwo_ff[7:0] <= bus.wrData;
                inhTwo_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // halt arming of capture edges
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            haltArm_ff <= 2'h0;
            haltPrev_ff <= 1'b0;
        end else if (clkEn) begin
            haltPrev_ff <= haltMode;
            // arm on edge in halt, release at exit
            if (haltExit) begin
                haltArm_ff <= 2'h0;
            end else if (haltMode) begin
                haltArm_ff <= haltArm_ff | {edgeTwo, edgeOne};
            end
        end
    end

    // capture flag one doubles as period mark in pwm
    assign setIcf1 = (run && (edgeOne || (pwmOn && matchTwo))) ||
                     (clkEn && haltExit && haltArm_ff[0]);
    assign setIcf2 = (run && edgeTwo) ||
                     (clkEn && haltExit && haltArm_ff[1]);
    // compare flags never set in pwm
    assign setOcf1 = run && matchOne && !pwmOn && !opmOn;
    assign setOcf2 = run && matchTwo && !pwmOn;
    assign setTof = run && tick && (cnt_ff == CNT_TOP);

    // capture value registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            capOne_ff <= 16'h0;
            capTwo_ff <= 16'h0;
        end else begin
            // counter at halt exit is captured
            if (clkEn && haltExit && haltArm_ff[0]) begin
                capOne_ff <= cnt_ff;
            end else if (run && edgeOne) begin
                capOne_ff <= cnt_ff;
            end
            // capture two still loads in pwm
            if (clkEn && haltExit && haltArm_ff[1]) begin
                capTwo_ff <= cnt_ff;
            end else if (run && edgeTwo) begin
                capTwo_ff <= cnt_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // low byte accesses that finish a clear, order capture_flag_one..compare_flag_two
    assign lowAcc = {hit(bus, OFF_CAP1_LO), hit(bus, OFF_CMP1_LO),
                     hit(bus, OFF_CNT_LO), hit(bus, OFF_CAP2_LO),
                     hit(bus, OFF_CMP2_LO)};

    // status read arms, low access clears, set wins
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            armClr_ff <= 5'h0;
            capture_flag_one_ff <= 1'b0;
            compare_flag_one_ff <= 1'b0;
            tof_ff <= 1'b0;
            capture_flag_two_ff <= 1'b0;
            compare_flag_two_ff <= 1'b0;
        end else if (clkEn) begin
            if (bus.rdStb && bus.addr == OFF_STATUS) begin
                armClr_ff <= statusByte[7:3];
            end else begin
                armClr_ff <= armClr_ff & ~lowAcc;
            end
            capture_flag_one_ff <= setIcf1 || (capture_flag_one_ff && !(armClr_ff[4] && lowAcc[4]));
            compare_flag_one_ff <= setOcf1 || (compare_flag_one_ff && !(armClr_ff[3] && lowAcc[3]));
            tof_ff <= setTof || (tof_ff && !(armClr_ff[2] && lowAcc[2]));
            capture_flag_two_ff <= setIcf2 || (capture_flag_two_ff && !(armClr_ff[1] && lowAcc[1]));
            compare_flag_two_ff <= setOcf2 || (compare_flag_two_ff && !(armClr_ff[0] && lowAcc[0]));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output one, idle until enabled
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            outOne_ff <= 1'b0;
        end else if (run && ctrlTwo_ff.compareOnePinEnable) begin
            if (pwmOn) begin
                if (matchTwo) begin
                    outOne_ff <= ctrlOne_ff.levelAfterCompareTwo;
                end else if (matchOne) begin
                    outOne_ff <= ctrlOne_ff.levelAfterCompareOne;
                end
            end else if (matchOne || ctrlOne_ff.forceLevelOne) begin
                outOne_ff <= ctrlOne_ff.levelAfterCompareOne;
            end
        end
    end

    // compare output two; pwm leaves it to forcing only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            outTwo_ff <= 1'b0;
        end else if (run && ctrlTwo_ff.compareTwoPinEnable) begin
            // force copies level two without a match
            if (ctrlOne_ff.forceLevelTwo || (matchTwo && !pwmOn)) begin
                outTwo_ff <= ctrlOne_ff.levelAfterCompareTwo;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shared interrupt and wake request
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else if (clkEn) begin
            irq_ff <= !globalInterruptMask && (
                (ctrlOne_ff.captureInterruptEnable && (capture_flag_one_ff || capture_flag_two_ff)) ||
                (ctrlOne_ff.compareInterruptEnable && (compare_flag_one_ff || compare_flag_two_ff)) ||
                (ctrlOne_ff.overflowInterruptEnable && tof_ff));
            wake_ff <= irq_ff && waitMode && !haltMode;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdData_ff <= 8'h0;
        end else if (clkEn) begin
            rdData_ff <= 8'h0;
            if (bus.rdStb) begin
                case (bus.addr)
                    OFF_CTRL_TWO: rdData_ff <= ctrlTwo_ff;
                    OFF_CTRL_ONE: rdData_ff <= ctrlOne_ff;
                    OFF_STATUS: rdData_ff <= statusByte;
                    OFF_CAP1_HI: rdData_ff <= capOne_ff[15:8];
                    OFF_CAP1_LO: rdData_ff <= capOne_ff[7:0];
                    OFF_CMP1_HI: rdData_ff <= cmpOne_ff[15:8];
                    OFF_CMP1_LO: rdData_ff <= cmpOne_ff[7:0];
                    OFF_CNT_HI: rdData_ff <= cnt_ff[15:8];
                    OFF_CNT_LO: rdData_ff <= cnt_ff[7:0];
                    OFF_ACNT_HI: rdData_ff <= cnt_ff[15:8];
                    OFF_ACNT_LO: rdData_ff <= cnt_ff[7:0];
                    OFF_CAP2_HI: rdData_ff <= capTwo_ff[15:8];
                    OFF_CAP2_LO: rdData_ff <= capTwo_ff[7:0];
                    OFF_CMP2_HI: rdData_ff <= cmpTwo_ff[15:8];
                    OFF_CMP2_LO: rdData_ff <= cmpTwo_ff[7:0];
                    default: rdData_ff <= 8'h0;
                endcase
            end
        end
    end

    assign rdData = rdData_ff;
    assign compareOutputOne = outOne_ff;
    assign compareOutputTwo = outTwo_ff;
    assign timerIrq = irq_ff;
    assign waitWake = wake_ff;

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_period_end;
        run && pwmOn && matchTwo;
    endsequence

    sequence s_capture_flag_one_clear;
        clkEn && armClr_ff[4] && lowAcc[4] && !setIcf1;
    endsequence

    a_pwm_reload: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_period_end and !(bus.wrStb && bus.addr == OFF_CNT_LO))
        |=> cnt_ff == RST_CNT)
        else $error("counter not reloaded at period end");

    // period end marks capture flag one
    a_pwm_mark: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_period_end |=> capture_flag_one_ff)
        else $error("capture flag one missed period end");

    // compare flags stay clear in pwm
    a_pwm_noflag: assert property (@(posedge clk_sys) disable iff (!nrst)
        pwmOn && !compare_flag_one_ff && !compare_flag_two_ff |=> !compare_flag_one_ff && !compare_flag_two_ff)
        else $error("compare flag set in pwm");

    a_pwm_level: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_period_end and ctrlTwo_ff.compareOnePinEnable)
        |=> outOne_ff == $past(ctrlOne_ff.levelAfterCompareTwo))
        else $error("output one missed period level");

    a_pwm_steady: assert property (@(posedge clk_sys) disable iff (!nrst)
        pwmOn && ctrlOne_ff.levelAfterCompareOne ==
        ctrlOne_ff.levelAfterCompareTwo &&
        outOne_ff == ctrlOne_ff.levelAfterCompareOne
        |=> outOne_ff == $past(outOne_ff))
        else $error("output one toggled with equal levels");

    a_cmp_inhibit: assert property (@(posedge clk_sys) disable iff (!nrst)
        inhOne_ff && !compare_flag_one_ff |=> !compare_flag_one_ff)
        else $error("inhibited compare set flag");

    // two-step clear of capture flag one
    a_flag_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_capture_flag_one_clear |=> !capture_flag_one_ff)
        else $error("capture flag one not cleared");

    a_irq_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
        clkEn && globalInterruptMask |=> !timerIrq)
        else $error("interrupt while masked");

    a_irq_ovf: assert property (@(posedge clk_sys) disable iff (!nrst)
        clkEn && !globalInterruptMask && tof_ff &&
        ctrlOne_ff.overflowInterruptEnable |=> timerIrq)
        else $error("overflow request missing");

    a_halt_freeze: assert property (@(posedge clk_sys) disable iff (!nrst)
        haltMode && !bus.wrStb |=> cnt_ff == $past(cnt_ff))
        else $error("counter moved in halt");

    // wait wake follows request, never in halt
    a_wait_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
        clkEn && timerIrq && waitMode && !haltMode
        |-> ##[W_MIN:W_MAX] waitWake)
        else $error("no wake from wait");

    a_halt_nowake: assert property (@(posedge clk_sys) disable iff (!nrst)
        clkEn && haltMode |=> !waitWake)
        else $error("wake during halt");

endmodule // tpw_timer

// ---- dv/tpw_cpu_model.sv ----
`timescale 1ns/1ps
// core side of the register port: one-cycle strobes, no wait states
module tpw_cpu_model (
    // clock
    input wire logic clk_sys,
    // register port
    output tpw_pkg::tpw_bus_t bus,
    input wire logic [7:0] rdData
);
    import tpw_pkg::*;

    // idle bus from time zero
    initial begin
        bus = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // write: strobe for exactly one edge, then idle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= {a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus <= '0;
    endtask

    // read: data only stand in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus <= '0;
        #1;
        d = rdData;
    endtask
endmodule // tpw_cpu_model

// ---- dv/tpw_timer_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    num_errors++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tpw_timer_tb;
    import tpw_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic capTwo = 1'b1;
    logic mask = 1'b0;
    logic waitMode = 1'b0;
    logic haltMode = 1'b0;
    tpw_bus_t bus;
    logic [7:0] rdData;
    logic [7:0] d;
    logic [7:0] d2;
    logic out1;
    logic out2;
    logic irq;
    logic wake;
    int num_errors = 0;
    int n_compared = 0;
    int hi;
    int per;
    int c;
    int dv[3] = '{4, 2, 8};

    // 50 mhz system clock
    always #10 clk_sys = ~clk_sys;

    tpw_cpu_model tpw_cpu_model_i (.clk_sys(clk_sys), .bus(bus),
        .rdData(rdData));
    tpw_timer tpw_timer_i (.clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1),
        .bus(bus), .rdData(rdData), .captureInputOne(1'b0),
        .captureInputTwo(capTwo), .extClockIn(1'b0),
        .compareOutputOne(out1), .compareOutputTwo(out2),
        .globalInterruptMask(mask), .waitMode(waitMode),
        .haltMode(haltMode), .timerIrq(irq), .waitWake(wake));

    ////////////////////////////////////////////////////////////////////////
    // sample just after the edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask

    // one full pulse of output one, in clk cycles; bounded wait
    task automatic measure(output int h, output int p);
        int n;
        n = 0;
        while (out1 !== 1'b0 && n < 900) begin tick(1); n++; end
        while (out1 !== 1'b1 && n < 900) begin tick(1); n++; end
        h = 0;
        while (out1 === 1'b1 && n < 900) begin tick(1); h++; n++; end
        p = h;
        while (out1 === 1'b0 && n < 900) begin tick(1); p++; n++; end
    endtask

    // settle one period, then count cycles at a level over 250
    task automatic countLevel(input logic lvl, output int k);
        tick(250);
        k = 0;
        repeat (250) begin tick(1); if (out1 === lvl) k++; end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard: the sequence needs well under 10000 cycles
    initial begin
        #400000;
        num_errors++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        tpw_cpu_model_i.rd(OFF_CTRL_ONE, d);
        `CHK("ctrl one rst", 8'h00, d)
        tpw_cpu_model_i.rd(OFF_CMP2_HI, d);
        `CHK("cmp2 hi rst", 8'h80, d)
        tpw_cpu_model_i.rd(OFF_STATUS, d);
        `CHK("status rst", 8'h00, d)
        tpw_cpu_model_i.rd(4'hf, d);
        `CHK("unmapped", 8'h00, d)
        `CHK("out1 idle", 1'b0, out1)
        tpw_cpu_model_i.wr(OFF_CMP2_HI, 8'h00);
        tpw_cpu_model_i.wr(OFF_CMP2_LO, 8'h14);
        tpw_cpu_model_i.wr(OFF_CMP1_HI, 8'h00);
        tpw_cpu_model_i.wr(OFF_CMP1_LO, 8'h0a);
        tpw_cpu_model_i.wr(OFF_CTRL_ONE, 8'h81);
        // single pulse also set: pwm must win
        for (int s = 0; s < 3; s++) begin
            tpw_cpu_model_i.wr(OFF_CTRL_TWO, 8'hb0 | 8'(s << 2));
            measure(hi, per);
            measure(hi, per);
            `CHK("pulse high", 10 * dv[s], hi)
            `CHK("period", 25 * dv[s], per)
        end
        tpw_cpu_model_i.rd(OFF_STATUS, d);
        `CHK("capture_flag_one set", 1'b1, d[7])
        `CHK("ocf clear", 2'b00, {d[6], d[3]})
        `CHK("irq on", 1'b1, irq)
        tpw_cpu_model_i.rd(OFF_CAP1_LO, d);
        tpw_cpu_model_i.rd(OFF_STATUS, d);
        `CHK("capture_flag_one cleared", 1'b0, d[7])
        `CHK("irq off", 1'b0, irq)
        measure(hi, per);
        @(posedge clk_sys) mask <= 1'b1;
        tick(2);
        `CHK("irq masked", 1'b0, irq)
        @(posedge clk_sys) mask <= 1'b0;
        tick(2);
        `CHK("irq unmasked", 1'b1, irq)
        @(posedge clk_sys) waitMode <= 1'b1;
        tick(3);
        `CHK("wait wake", 1'b1, wake)
        @(posedge clk_sys) haltMode <= 1'b1;
        tick(3);
        `CHK("no halt wake", 1'b0, wake)
        tpw_cpu_model_i.rd(OFF_ACNT_LO, d);
        tick(40);
        tpw_cpu_model_i.rd(OFF_ACNT_LO, d2);
        `CHK("halt frozen", d, d2)
        @(posedge clk_sys) haltMode <= 1'b0;
        waitMode <= 1'b0;
        // high byte alone inhibits the pulse start
        tpw_cpu_model_i.wr(OFF_CMP1_HI, 8'h00);
        countLevel(1'b1, c);
        `CHK("cmp1 inhibited", 0, c)
        tpw_cpu_model_i.wr(OFF_CMP1_LO, 8'h0a);
        measure(hi, per);
        `CHK("cmp1 resumed", 80, hi)
        tpw_cpu_model_i.wr(OFF_CTRL_ONE, 8'h85);
        countLevel(1'b0, c);
        `CHK("equal levels", 0, c)
        @(posedge clk_sys) capTwo <= 1'b0;
        tick(6);
        tpw_cpu_model_i.rd(OFF_STATUS, d);
        `CHK("capture_flag_two in pwm", 1'b1, d[4])
        // clear capture_flag_two, then a capture edge inside halt only arms
        tpw_cpu_model_i.rd(OFF_CAP2_LO, d);
        @(posedge clk_sys) capTwo <= 1'b1;
        haltMode <= 1'b1;
        tick(6);
        @(posedge clk_sys) capTwo <= 1'b0;
        tick(6);
        tpw_cpu_model_i.rd(OFF_ACNT_LO, d);
        tpw_cpu_model_i.rd(OFF_STATUS, d2);
        `CHK("no capture_flag_two in halt", 1'b0, d2[4])
        @(posedge clk_sys) haltMode <= 1'b0;
        tick(2);
        tpw_cpu_model_i.rd(OFF_STATUS, d2);
        `CHK("capture_flag_two at halt exit", 1'b1, d2[4])
        tpw_cpu_model_i.rd(OFF_CAP2_LO, d2);
        `CHK("cap2 at halt exit", d, d2)
        tpw_cpu_model_i.wr(OFF_CTRL_TWO, 8'hf8);
        tpw_cpu_model_i.wr(OFF_CTRL_ONE, 8'h14);
        tick(3);
        `CHK("force two", 1'b1, out2)
        // plain compare mode: counter reaches compare two
        tpw_cpu_model_i.wr(OFF_CTRL_TWO, 8'h40);
        tick(200);
        `CHK("cmp irq gated", 1'b0, irq)
        tpw_cpu_model_i.wr(OFF_CTRL_ONE, 8'h54);
        tick(3);
        tpw_cpu_model_i.rd(OFF_STATUS, d);
        `CHK("compare_flag_two set", 1'b1, d[3])
        `CHK("cmp irq", 1'b1, irq)
        `CHK("tof set", 1'b1, d[5])
        tpw_cpu_model_i.wr(OFF_CTRL_ONE, 8'h34);
        tick(3);
        `CHK("ovf irq", 1'b1, irq)
        test_done();
    end
endmodule // tpw_timer_tb
